/* File: core/gpio_consts.svh */
/*
 * Constants of the general-purpose pin block: register indices, bit masks
 * of implemented bits, reset values and edge-select codes.
 * Assumes it is included by bare name from the core files.
 */
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_PORT0_DIR 8'hb8
`define IDX_PORT1_DIR 8'hc1
`define IDX_PORT2_DIR 8'hc2
`define IDX_PORT5_DIR 8'hc5
`define IDX_PORT0_PU 8'he0
`define IDX_PORT1_PU 8'he1
`define IDX_PORT2_PU 8'he2
`define IDX_PORT5_PU 8'he5
`define IDX_OD_CTRL 8'he9
// Bit set and bit clear aliases of the direction registers, low bits = port
`define IDX_DIR_SET_BASE 5'h1e
`define IDX_DIR_CLR_BASE 5'h1f
// Pin level readback
`define IDX_PIN_LEVEL 8'hee

// Implemented bits per port (P1.1 has no direction and no pull-up bit)
`define MASK_PORT0 8'h01
`define MASK_PORT1 8'h0d
`define MASK_PORT2 8'h3f
`define MASK_PORT5 8'h10
`define MASK_OD 8'h01

// Reset values
`define RST_DIR 8'h00
`define RST_PU 8'h00
`define RST_OD 8'h00

// Pin positions in the flat twelve-pin vector
`define PIN_P00 0
`define PIN_P10 1
`define PIN_P11 2
`define PIN_P12 3
`define PIN_P13 4
`define PIN_P54 11

// Edge select codes for the external interrupt input
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2

`endif

/* File: core/gpio_pin_cell.sv */
/*
 * One pin's output stage: direction, open-drain, pull-up and takeover by
 * a shared function, with registered pad controls.
 * Assumes the pad combines pin_o, pin_oe_o and pin_pu_o into the wire.
 */
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_cell #(
    parameter bit OUT_CAPABLE = 1'b1,
    parameter bit OD_CAPABLE = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Settings from the register file
    input wire logic dir_i,
    input wire logic pu_en_i,
    input wire logic od_en_i,
    input wire logic data_i,
    // Shared function takeover
    input wire logic alt_en_i,
    input wire logic alt_data_i,
    input wire logic release_i,
    // Pad controls
    output logic pin_o,
    output logic pin_oe_o,
    output logic pin_pu_o
);

    logic drive_d; // Pad driven this cycle
    logic level_d; // Level put on the pad
    logic od_mode; // Open-drain in force

    assign od_mode = OD_CAPABLE && od_en_i;

    // Output enable and level from mode, open-drain and takeover
    always_comb begin
        drive_d = 1'b0;
        level_d = 1'b0;
        if (release_i || !OUT_CAPABLE) begin
            // Analog or input-only use: pad left to others
            drive_d = 1'b0;
        end else if (alt_en_i) begin
            // Shared digital output owns the pin
            drive_d = 1'b1;
            level_d = alt_data_i;
        end else if (od_mode) begin
            drive_d = !data_i;
            level_d = 1'b0;
        end else begin
            drive_d = dir_i;
            level_d = data_i;
        end
    end

    // Registered pad controls so the pad sees no glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            pin_pu_o <= 1'b0;
        end else begin
            pin_o <= level_d;
            pin_oe_o <= drive_d;
            pin_pu_o <= OUT_CAPABLE && pu_en_i && !dir_i && !od_mode
                        && !alt_en_i && !release_i;
        end
    end

endmodule // gpio_pin_cell

`default_nettype wire

/* File: core/gpio_pkg.sv */
/*
 * Types of the general-purpose pin block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpio_pkg;

    // High clock build-time option
    typedef enum logic [2:0] {
        HCLK_INT_RC = 3'b000,
        HCLK_RC = 3'b001,
        HCLK_32K = 3'b010,
        HCLK_4M = 3'b011,
        HCLK_12M = 3'b100,
        HCLK_INT_RC_RTC = 3'b101
    } high_clk_e;

    // Port slot: ports 0, 1, 2, 5 held in four slots
    typedef logic [1:0] port_slot_t;

endpackage

/* File: core/gpio_port_control.sv */
/*
 * Twelve-pin general-purpose port block: direction, pull-up and
 * open-drain registers on a classic Wishbone slave, shared-function
 * takeover of pins, and the external interrupt edge detector.
 * Assumes all inputs are synchronous to clk_i and that the port data
 * values arrive from the data register block outside.
 */
`timescale 1ns/100ps
`default_nettype none

`include "gpio_consts.svh"

module gpio_port_control
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Pads, one bit per pin
    input wire logic [11:0] pin_i,
    output logic [11:0] pin_o,
    output logic [11:0] pin_oe_o,
    output logic [11:0] pin_pu_o,
    // Port data from the data register block, one bit per pin
    input wire logic [11:0] port_data_i,
    output logic [11:0] pin_level_o,
    // Build-time options
    input wire logic reset_pin_opt_i,
    input wire logic [2:0] high_clk_opt_i,
    // Timer and interrupt controls
    input wire logic timer_counter_enable_i,
    input wire logic pwm_output_enable_i,
    input wire logic toggle_output_enable_i,
    input wire logic pwm_output_i,
    input wire logic buzzer_output_i,
    input wire logic ext_int_enable_i,
    input wire logic [1:0] edge_select_i,
    // Shared function outputs
    output logic ext_int_input_o,
    output logic ext_reset_n_o,
    output logic osc_input_o,
    output logic osc_output_claim_o
);

    // Direction and pull-up storage, one byte per port slot
    logic [7:0] dir_q [4];
    logic [7:0] pu_q [4];
    logic [7:0] od_q; // Open-drain control byte
    logic ack_q; // Bus answer
    logic [31:0] dat_q; // Registered read data
    logic [7:0] rd_byte; // Read mux result
    logic req; // New bus request this cycle
    logic wr_lo; // Write that carries byte lane 0
    logic hi_zero; // Address bits outside the decoded index are zero
    logic [7:0] idx; // Register index
    logic [7:0] mask [4]; // Implemented bits per slot
    logic [7:0] dir_idx [4]; // Direction register index per slot
    logic [7:0] pu_idx [4]; // Pull-up register index per slot
    logic [2:0] port_num [4]; // Port number per slot
    logic [11:0] dir_pin; // Direction per pin
    logic [11:0] pu_pin; // Pull-up enable per pin
    logic [11:0] alt_en; // Shared digital output owns pin
    logic [11:0] alt_data; // Level of the shared output
    logic [11:0] release_pin; // Analog or reset takeover, pad released
    logic osc_in_claim; // P1.3 taken by the oscillator
    logic osc_out_claim; // P1.2 taken by the oscillator
    logic reset_claim; // P1.1 is the external reset
    logic pwm_sel; // P5.4 carries PWM
    logic buz_sel; // P5.4 carries buzzer
    logic p00_prev_q; // Last sample of P0.0
    logic [11:0] level_q; // Pin levels seen by software

    // Per-slot constants: port 0, 1, 2 and 5
    // Twelve pins on four ports
    assign mask[0] = `MASK_PORT0;
    assign mask[1] = `MASK_PORT1;
    assign mask[2] = `MASK_PORT2;
    assign mask[3] = `MASK_PORT5;
    assign dir_idx[0] = `IDX_PORT0_DIR;
    assign dir_idx[1] = `IDX_PORT1_DIR;
    assign dir_idx[2] = `IDX_PORT2_DIR;
    assign dir_idx[3] = `IDX_PORT5_DIR;
    assign pu_idx[0] = `IDX_PORT0_PU;
    assign pu_idx[1] = `IDX_PORT1_PU;
    assign pu_idx[2] = `IDX_PORT2_PU;
    assign pu_idx[3] = `IDX_PORT5_PU;
    assign port_num[0] = 3'h0;
    assign port_num[1] = 3'h1;
    assign port_num[2] = 3'h2;
    assign port_num[3] = 3'h5;

    // Bus decode; word index sits in byte address bits 9:2
    assign idx = adr_i[9:2];
    assign hi_zero = (adr_i[31:10] == 22'h000000) && (adr_i[1:0] == 2'h0);
    assign req = cyc_i && stb_i && !ack_q;
    assign wr_lo = req && we_i && sel_i[0] && hi_zero;

    // Answer every request one cycle later, mapped or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    assign ack_o = ack_q;

    // Direction registers, one process per slot
    genvar s;
    generate
        for (s = 0; s < 4; s++) begin : g_slot
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    dir_q[s] <= `RST_DIR;
                end else if (wr_lo && idx == dir_idx[s]) begin
                    dir_q[s] <= dat_i[7:0] & mask[s];
                end else if (wr_lo && idx == {`IDX_DIR_SET_BASE,
                                               port_num[s]}) begin
                    dir_q[s] <= dir_q[s] | (dat_i[7:0] & mask[s]);
                end else if (wr_lo && idx == {`IDX_DIR_CLR_BASE,
                                               port_num[s]}) begin
                    dir_q[s] <= dir_q[s] & ~dat_i[7:0];
                end
            end

            // Pull-up registers, write only
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pu_q[s] <= `RST_PU;
                end else if (wr_lo && idx == pu_idx[s]) begin
                    pu_q[s] <= dat_i[7:0] & mask[s];
                end
            end
        end
    endgenerate

    // Open-drain control, write only and taken a byte at a time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            od_q <= `RST_OD;
        end else if (wr_lo && idx == `IDX_OD_CTRL) begin
            od_q <= dat_i[7:0] & `MASK_OD;
        end
    end

    // Read mux; write-only and unmapped registers read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (hi_zero) begin
            case (idx)
                `IDX_PORT0_DIR: begin
                    rd_byte = dir_q[0];
                end
                `IDX_PORT1_DIR: begin
                    rd_byte = dir_q[1];
                end
                `IDX_PORT2_DIR: begin
                    rd_byte = dir_q[2];
                end
                `IDX_PORT5_DIR: begin
                    rd_byte = dir_q[3];
                end
                `IDX_PIN_LEVEL: begin
                    // Only the low byte fits here; see level bits below
                    rd_byte = level_q[7:0];
                end
                default: begin
                    // Pull-up and open-drain hide their contents
                    rd_byte = 8'h00;
                end
            endcase
        end
    end

    // Registered read data; pin level register carries all twelve bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (req && !we_i) begin
            if (hi_zero && idx == `IDX_PIN_LEVEL) begin
                dat_q <= {20'h00000, level_q};
            end else begin
                dat_q <= {24'h000000, rd_byte};
            end
        end
    end

    assign dat_o = dat_q;

    // Oscillator and reset takeover from the build-time options
    always_comb begin
        osc_in_claim = 1'b0;
        osc_out_claim = 1'b0;
        case (high_clk_opt_i)
            HCLK_RC: begin
                osc_in_claim = 1'b1;
            end
            HCLK_32K, HCLK_4M, HCLK_12M, HCLK_INT_RC_RTC: begin
                osc_in_claim = 1'b1;
                osc_out_claim = 1'b1;
            end
            default: begin
                // Internal oscillator leaves both pins free
                osc_in_claim = 1'b0;
            end
        endcase
    end

    assign reset_claim = reset_pin_opt_i;
    assign ext_reset_n_o = reset_claim ? pin_i[`PIN_P11] : 1'b1;
    assign osc_input_o = osc_in_claim ? pin_i[`PIN_P13] : 1'b0;
    assign osc_output_claim_o = osc_out_claim;

    assign pwm_sel = timer_counter_enable_i && pwm_output_enable_i;
    assign buz_sel = timer_counter_enable_i && toggle_output_enable_i
                     && !pwm_output_enable_i;

    // Flat per-pin vectors: P5.4, P2.5..P2.0, P1.3..P1.0, P0.0
    assign dir_pin = {dir_q[3][4], dir_q[2][5:0], dir_q[1][3:0],
                      dir_q[0][0]};
    assign pu_pin = {pu_q[3][4], pu_q[2][5:0], pu_q[1][3:0], pu_q[0][0]};

    // Takeover masks per pin
    always_comb begin
        alt_en = 12'h000;
        alt_data = 12'h000;
        release_pin = 12'h000;
        alt_en[`PIN_P54] = pwm_sel || buz_sel;
        alt_data[`PIN_P54] = pwm_sel ? pwm_output_i : buzzer_output_i;
        release_pin[`PIN_P12] = osc_out_claim;
        release_pin[`PIN_P13] = osc_in_claim;
        release_pin[`PIN_P11] = reset_claim;
    end

    // One output stage per pin; P1.1 cannot drive, P1.0 alone can be open-drain
    genvar p;
    generate
        for (p = 0; p < 12; p++) begin : g_pin
            gpio_pin_cell #(
                .OUT_CAPABLE(p != `PIN_P11),
                .OD_CAPABLE(p == `PIN_P10)
            ) u_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .dir_i(dir_pin[p]),
                .pu_en_i(pu_pin[p]),
                .od_en_i(od_q[0]),
                .data_i(port_data_i[p]),
                .alt_en_i(alt_en[p]),
                .alt_data_i(alt_data[p]),
                .release_i(release_pin[p]),
                .pin_o(pin_o[p]),
                .pin_oe_o(pin_oe_o[p]),
                .pin_pu_o(pin_pu_o[p])
            );
        end
    endgenerate

    // Pin levels for software; P1.1 forced high in reset use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= 12'h000;
        end else begin
            level_q <= pin_i;
            if (reset_claim) begin
                level_q[`PIN_P11] <= 1'b1;
            end
        end
    end

    assign pin_level_o = level_q;

    // Previous P0.0 sample for the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Track the pin so a high idle level gives no edge after reset
            p00_prev_q <= pin_i[`PIN_P00];
        end else begin
            p00_prev_q <= pin_i[`PIN_P00];
        end
    end

    // One-cycle request on the chosen edge while the input is enabled
    always_comb begin
        ext_int_input_o = 1'b0;
        if (ext_int_enable_i) begin
            case (edge_select_i)
                `EDGE_FALL: begin
                    ext_int_input_o = p00_prev_q && !pin_i[`PIN_P00];
                end
                `EDGE_RISE: begin
                    ext_int_input_o = !p00_prev_q && pin_i[`PIN_P00];
                end
                `EDGE_BOTH: begin
                    ext_int_input_o = p00_prev_q ^ pin_i[`PIN_P00];
                end
                default: begin
                    // Unused code gives no requests
                    ext_int_input_o = 1'b0;
                end
            endcase
        end
    end

endmodule // gpio_port_control

`default_nettype wire

/* File: testbench/gpio_port_chk.sv */
/* Checker of the pin block: bus handshake, pad controls and shared pins.
   Assumes it is bound to gpio_port_control and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module gpio_port_chk (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Pads
    input wire logic [11:0] pin_i,
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe_o,
    input wire logic [11:0] pin_pu_o,
    input wire logic [11:0] port_data_i,
    input wire logic [11:0] pin_level_o,
    // Options and shared functions
    input wire logic reset_pin_opt_i,
    input wire logic [2:0] high_clk_opt_i,
    input wire logic timer_counter_enable_i,
    input wire logic pwm_output_enable_i,
    input wire logic pwm_output_i,
    input wire logic ext_int_enable_i,
    input wire logic [1:0] edge_select_i,
    input wire logic ext_int_input_o,
    input wire logic ext_reset_n_o,
    input wire logic osc_input_o,
    input wire logic osc_output_claim_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Open-drain enable seen on the bus; the register itself is unreadable
    logic od_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            od_q <= 1'b0;
        end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]
                     && adr_i == 32'h0000_03a4) begin
            od_q <= dat_i[0];
        end
    end

    AST_ACK_ONE: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack late or longer than one cycle");
    AST_ACK_CAUSE: assert property (
        ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without a request");
    AST_P11_PASSIVE: assert property (
        !pin_oe_o[2] && !pin_pu_o[2]) else $error("P1.1 driven or pulled");
    AST_PU_INPUT: assert property (
        (pin_pu_o & pin_oe_o) == 12'h000) else $error("pull-up on output");
    AST_OD_DRIVE: assert property (
        $past(od_q) && !$past(rst_i) |-> !pin_o[1]
        && pin_oe_o[1] == !$past(port_data_i[1]))
        else $error("open-drain pad wrong");
    AST_OSC_IN: assert property (
        osc_input_o == (high_clk_opt_i inside {[3'd1:3'd5]} && pin_i[4]))
        else $error("oscillator input wrong");
    AST_OSC_OUT: assert property (
        osc_output_claim_o == (high_clk_opt_i inside {[3'd2:3'd5]}))
        else $error("oscillator output claim wrong");
    AST_RST_PIN: assert property (
        ext_reset_n_o == (reset_pin_opt_i ? pin_i[2] : 1'b1))
        else $error("reset input wrong");
    AST_P11_READ: assert property (
        reset_pin_opt_i && $past(reset_pin_opt_i) && !$past(rst_i)
        |-> pin_level_o[2]) else $error("P1.1 level not one");
    AST_PWM: assert property (
        $past(timer_counter_enable_i && pwm_output_enable_i) && !$past(rst_i)
        |-> pin_o[11] == $past(pwm_output_i)) else $error("P5.4 not PWM");
    AST_EDGE: assert property (
        ext_int_enable_i && !$past(rst_i) |-> ext_int_input_o ==
        (edge_select_i == 2'h0 ? $fell(pin_i[0]) : edge_select_i == 2'h1 ?
        $rose(pin_i[0]) : edge_select_i == 2'h2 && $changed(pin_i[0])))
        else $error("interrupt edge wrong");
    AST_LEVEL: assert property (
        !reset_pin_opt_i && !$past(reset_pin_opt_i) && !$past(rst_i)
        |-> pin_level_o == $past(pin_i)) else $error("pin level stale");
endmodule // gpio_port_chk

`default_nettype wire

/* File: testbench/pin_board.sv */
/* Board model on the twelve pins: pad drivers, pulls, the resistor on
   P1.0 and bench drivers. Assumes pad controls come from the block. */
`timescale 1ns/100ps
`default_nettype none

module pin_board (
    // Clock
    input wire logic clk_i,
    // Pad controls of the block
    input wire logic [11:0] drv_i,
    input wire logic [11:0] drv_en_i,
    input wire logic [11:0] pu_en_i,
    // Bench drivers standing for board parts
    input wire logic [11:0] ext_en_i,
    input wire logic [11:0] ext_val_i,
    // Resolved wire levels
    output logic [11:0] level_o
);
    // Floating lines flip every cycle so a stale level never passes
    logic [11:0] float_q = 12'h000;
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int k = 0; k < 12; k++) begin
            if (drv_en_i[k]) begin
                level_o[k] = drv_i[k];
            end else if (ext_en_i[k]) begin
                level_o[k] = ext_val_i[k];
            end else if (pu_en_i[k] || k == 1) begin
                level_o[k] = 1'b1;
            end else begin
                level_o[k] = float_q[k];
            end
        end
    end
endmodule // pin_board

`default_nettype wire

/* File: testbench/tb.sv */
/* Self-checking bench of the pin block over classic Wishbone.
   Assumes the block answers each request with a one-cycle ack. */
`timescale 1ns/100ps
`default_nettype none

module tb;
    // Bus side
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
    logic [3:0] sel_i = 4'h0;
    // Pads and board drivers
    logic [11:0] pin_i, pin_o, pin_oe_o, pin_pu_o, pin_level_o;
    logic [11:0] port_data_i = 12'h000, ext_en = 12'h000, ext_val = 12'h000;
    // Options and shared functions
    logic reset_pin_opt_i = 1'b0, ext_int_enable_i = 1'b0;
    logic [2:0] high_clk_opt_i = 3'h0;
    logic timer_counter_enable_i = 1'b0, pwm_output_enable_i = 1'b0;
    logic toggle_output_enable_i = 1'b0, pwm_output_i = 1'b0;
    logic buzzer_output_i = 1'b0;
    logic [1:0] edge_select_i = 2'h3;
    logic ext_int_input_o, ext_reset_n_o, osc_input_o, osc_output_claim_o;
    // Bookkeeping
    int num_errors = 0, n_checks = 0, pulses = 0, p0, i;
    logic [31:0] seed = 32'h2bfc99e4;
    logic [31:0] exp_q[$];
    logic [3:0] e;
    logic c1, c2;
    logic [7:0] regs_t[10] = '{8'hb8, 8'hc1, 8'hc2, 8'hc5, 8'he0, 8'he1,
                               8'he2, 8'he5, 8'he9, 8'h10};
    logic [7:0] dir_t[4] = '{8'hb8, 8'hc1, 8'hc2, 8'hc5};
    logic [7:0] msk_t[4] = '{8'h01, 8'h0d, 8'h3f, 8'h10};
    int edge_t[4] = '{1, 1, 2, 0};

    always #2.5 clk_i = ~clk_i;

    gpio_port_control gpio_port_control_inst (.*);
    pin_board pin_board_inst (.clk_i(clk_i), .drv_i(pin_o),
        .drv_en_i(pin_oe_o), .pu_en_i(pin_pu_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pin_i));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string nm);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (num_errors == 0 && n_checks > 0 && exp_q.size() == 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; a read leaves its expected data in the queue
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, input logic [31:0] ex,
                       input logic [3:0] s = 4'h1);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= s;
        adr_i <= {22'h0, idx, 2'b00};
        dat_i <= {24'h0, d};
        if (!w) exp_q.push_back(ex);
        for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) begin
            num_errors++;
            report_and_stop();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // Pads are registered, so let a few edges pass before looking
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Read data meets the oldest note when ack shows
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0, "unexpected read");
            end else begin
                check(dat_o, exp_q.pop_front(), "read data");
            end
        end
    end

    // Interrupt pulses, one running count over all edge-select codes
    always @(posedge clk_i) begin
        if (ext_int_input_o === 1'b1) pulses <= pulses + 1;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, write-only reads and an unmapped place
        foreach (regs_t[k]) bus(0, regs_t[k], 8'h00, 32'h0);
        // Pin level readback with the board driving all twelve pins
        seed = lfsr(seed);
        @(posedge clk_i);
        ext_en <= 12'hfff;
        ext_val <= seed[11:0];
        bus(0, 8'hee, 8'h00, {20'h0, seed[11:0]});
        @(posedge clk_i);
        ext_en <= 12'h000;
        ext_val <= 12'h000;
        // Random bytes, only implemented bits stick
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            bus(1, dir_t[i], seed[7:0], 32'h0);
            bus(0, dir_t[i], 8'h00, {24'h0, seed[7:0] & msk_t[i]});
        end
        // Lane-less write dropped, set and clear touch only their bits
        bus(1, 8'hc2, 8'h2a, 32'h0);
        bus(1, 8'hc2, 8'h15, 32'h0, 4'h0);
        bus(1, 8'hf2, 8'h01, 32'h0);
        bus(1, 8'hfa, 8'h08, 32'h0);
        bus(0, 8'hc2, 8'h00, 32'h23);
        // Port 2 pads follow direction, data and pull-ups
        seed = lfsr(seed);
        @(posedge clk_i);
        port_data_i <= seed[11:0];
        bus(1, 8'he2, 8'h3f, 32'h0);
        settle();
        check(pin_oe_o[10:5], 6'h23, "p2 drive");
        check(pin_o[10:5] & 6'h23, seed[10:5] & 6'h23, "p2 data");
        check(pin_pu_o[10:5], 6'h1c, "p2 pull");
        // Port 1 pads, P1.1 stays passive
        bus(1, 8'hc1, 8'hff, 32'h0);
        bus(1, 8'he1, 8'hff, 32'h0);
        settle();
        check({pin_oe_o[4:1], pin_pu_o[4:1]}, 8'hd0, "p1 out");
        bus(1, 8'hc1, 8'h00, 32'h0);
        settle();
        check({pin_oe_o[4:1], pin_pu_o[4:1]}, 8'h0d, "p1 in");
        // Open drain on P1.0
        @(posedge clk_i);
        port_data_i[1] <= 1'b0;
        bus(1, 8'hc1, 8'h01, 32'h0);
        bus(1, 8'he9, 8'h01, 32'h0);
        settle();
        check({pin_oe_o[1], pin_o[1]}, 2'b10, "od low");
        @(posedge clk_i);
        port_data_i[1] <= 1'b1;
        settle();
        check({pin_oe_o[1], pin_pu_o[1], pin_level_o[1]}, 3'b001,
              "od hi");
        bus(1, 8'he9, 8'h00, 32'h0);
        settle();
        check({pin_oe_o[1], pin_o[1]}, 2'b11, "od off");
        // Every high-clock option on P1.2 and P1.3
        bus(1, 8'hc1, 8'h0c, 32'h0);
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            high_clk_opt_i <= i[2:0];
            settle();
            c1 = i inside {[1:5]};
            c2 = i inside {[2:5]};
            e = {c2, !c2, !c1, c1 & pin_i[4]};
            check({osc_output_claim_o, pin_oe_o[3], pin_oe_o[4],
                   osc_input_o}, e, "osc");
        end
        // Reset pin option on P1.1
        @(posedge clk_i);
        high_clk_opt_i <= 3'h0;
        reset_pin_opt_i <= 1'b1;
        ext_en[2] <= 1'b1;
        settle();
        check({ext_reset_n_o, pin_level_o[2]}, 2'b01,
              "rst on");
        @(posedge clk_i);
        reset_pin_opt_i <= 1'b0;
        settle();
        check({ext_reset_n_o, pin_level_o[2]}, 2'b10, "rst off");
        // All enable combinations on P5.4
        bus(1, 8'hc5, 8'h10, 32'h0);
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            {pwm_output_i, buzzer_output_i} <= i[3] ? 2'b01 : 2'b10;
            {timer_counter_enable_i, pwm_output_enable_i,
             toggle_output_enable_i} <= i[2:0];
            port_data_i[11] <= 1'b0;
            settle();
            e[0] = (i[2] && i[1]) ? !i[3] : (i[2] && i[0] && i[3]);
            check(pin_o[11], e[0], "p54");
        end
        // Each edge-select code on P0.0, one rise and one fall
        bus(1, 8'hb8, 8'h00, 32'h0);
        @(posedge clk_i);
        ext_int_enable_i <= 1'b1;
        ext_en[0] <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            edge_select_i <= i[1:0];
            settle();
            p0 = pulses;
            @(posedge clk_i);
            ext_val[0] <= 1'b1;
            settle();
            @(posedge clk_i);
            ext_val[0] <= 1'b0;
            settle();
            check(pulses - p0, edge_t[i], "edges");
        end
        report_and_stop();
    end
endmodule // tb

bind gpio_port_control gpio_port_chk gpio_port_chk_inst (.*);

`default_nettype wire
